// file: rtl/pdi_pkg.sv
// Shared constants and types for the power-delivery controller two-wire ports.
// Assumes a 50 MHz core clock; bus lines arrive from pins and are synchronised in the ports.
`default_nettype none
package pdi_pkg;
	localparam int          CLK_HZ         = 50_000_000;
	localparam int          SM_HZ          = 100_000;
	localparam int          FM_HZ          = 400_000;
	localparam int          SM_DIV         = CLK_HZ / (SM_HZ * 4);
	localparam int          FM_DIV         = CLK_HZ / (FM_HZ * 4);
	localparam int          DIV_W          = 8;
	localparam logic [3:0]  PORTA_ADDR_HI  = 4'h4;
	localparam logic [6:0]  PORTB_ADDR     = 7'h38;
	localparam logic [2:0]  DECODE_RST     = 3'h0;
	localparam logic [2:0]  DECODE_TIED_LO = 3'h0;
	localparam logic [2:0]  DECODE_TIED_HI = 3'h3;
	localparam logic [7:0]  EVT_RST        = 8'h00;
	localparam logic [6:0]  MASK_RST       = 7'h7F;
	localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
	typedef enum logic [2:0] {
		PDI_IDLE = 3'b000,
		PDI_ADDR = 3'b001,
		PDI_AACK = 3'b011,
		PDI_RX   = 3'b010,
		PDI_RACK = 3'b110,
		PDI_TX   = 3'b111,
		PDI_TACK = 3'b101
	} pdi_tgt_st_t;
	typedef enum logic [2:0] {
		PDC_IDLE  = 3'b000,
		PDC_START = 3'b001,
		PDC_BIT   = 3'b011,
		PDC_ACK   = 3'b010,
		PDC_STOP  = 3'b110
	} pdi_ctl_st_t;
endpackage
`default_nettype wire

// file: rtl/pdi_core_if.sv
// Carrier between a target port and the core: byte streams and events.
// Assumes both ends sit on the core clock.
`default_nettype none
interface pdi_core_if;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       start_seen;
	logic       stop_seen;
	logic       tx_req;
	logic       tx_ready;
	logic [7:0] tx_data;
	logic       busy;
	modport port (output rx_valid, output rx_data, output start_seen, output stop_seen,
		output tx_req, input tx_ready, input tx_data, output busy);
	modport core (input rx_valid, input rx_data, input start_seen, input stop_seen,
		input tx_req, output tx_ready, output tx_data, input busy);
endinterface
`default_nettype wire

// file: rtl/pdi_target.sv
// One two-wire target port: start/stop detect, address match, ack, stretching.
// Assumes the bus lines are raw pin levels; synchronised here before use.
`default_nettype none
module pdi_target
	import pdi_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       ce,
	input  wire logic       enable,
	input  wire logic [6:0] own_addr,
	input  wire logic [6:0] addr_mask,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_oe,
	output logic            sda_oe,
	pdi_core_if.port        cif
);
	logic [1:0]  scl_s_r, sda_s_r;
	logic        scl_d_r, sda_d_r;
	pdi_tgt_st_t st_r, st_nxt;
	logic [7:0]  sh_r;
	logic [3:0]  cnt_r;
	logic        rw_r, sda_oe_r, hold_r, nack_r;
	wire scl     = scl_s_r[1];
	wire sda     = sda_s_r[1];
	wire scl_re  = scl & ~scl_d_r;
	wire scl_fe  = ~scl & scl_d_r;
	wire start_c = scl & scl_d_r & sda_d_r & ~sda;
	wire stop_c  = scl & scl_d_r & ~sda_d_r & sda;
	wire byte_in = scl_re & (cnt_r == BITS_PER_BYTE - 4'h1);
	// After eight shifts the address sits above the direction bit.
	wire match   = ((sh_r[7:1] ^ own_addr) & addr_mask) == 7'h00;
	wire ack_slot = st_r == PDI_AACK || st_r == PDI_RACK || st_r == PDI_TACK;
	wire last_fe = scl_fe & (cnt_r == BITS_PER_BYTE);
	assign scl_oe         = hold_r;
	assign sda_oe         = sda_oe_r;
	assign cif.start_seen = start_c;
	assign cif.stop_seen  = stop_c;
	assign cif.busy       = st_r != PDI_IDLE;
	assign cif.tx_req     = hold_r & rw_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else if (ce) begin
			scl_s_r <= {scl_s_r[0], scl_in};
			sda_s_r <= {sda_s_r[0], sda_in};
			scl_d_r <= scl;
			sda_d_r <= sda;
		end
	end
	// A start or stop ends any frame regardless of state, so a glitchy host cannot wedge the port.
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			PDI_IDLE: st_nxt = st_r;
			PDI_ADDR: if (last_fe) st_nxt = (match && enable) ? PDI_AACK : PDI_IDLE;
			PDI_AACK: if (scl_fe) st_nxt = rw_r ? PDI_TX : PDI_RX;
			PDI_RX:   if (last_fe) st_nxt = PDI_RACK;
			PDI_RACK: if (scl_fe) st_nxt = PDI_RX;
			PDI_TX:   if (last_fe) st_nxt = PDI_TACK;
			PDI_TACK: if (scl_re && sda) st_nxt = PDI_IDLE;
				else if (scl_fe) st_nxt = PDI_TX;
		endcase
		if (start_c) st_nxt = PDI_ADDR;
		else if (stop_c) st_nxt = PDI_IDLE;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r     <= PDI_IDLE;
			sh_r     <= 8'h00;
			cnt_r    <= 4'h0;
			rw_r     <= 1'b0;
			sda_oe_r <= 1'b0;
			hold_r   <= 1'b0;
			nack_r   <= 1'b0;
			cif.rx_valid <= 1'b0;
			cif.rx_data  <= 8'h00;
		end else if (ce) begin
			st_r         <= st_nxt;
			cif.rx_valid <= 1'b0;
			if (start_c || stop_c || scl_fe && cnt_r == BITS_PER_BYTE)
				cnt_r <= 4'h0;
			else if (scl_re && cnt_r < BITS_PER_BYTE && !ack_slot)
				cnt_r <= cnt_r + 4'h1;
			if (scl_re && (st_r == PDI_ADDR || st_r == PDI_RX))
				sh_r <= {sh_r[6:0], sda};
			if (byte_in && st_r == PDI_ADDR)
				rw_r <= sda;
			if (byte_in && st_r == PDI_RX) begin
				cif.rx_valid <= 1'b1;
				cif.rx_data  <= {sh_r[6:0], sda};
			end
			// Stretch after the read address ack and each host-acked read byte until the core gives the next one.
			if (scl_fe && (st_r == PDI_AACK && rw_r || st_r == PDI_TACK && !sda_d_r))
				hold_r <= 1'b1;
			else if (hold_r && cif.tx_ready) begin
				hold_r <= 1'b0;
				sh_r   <= cif.tx_data;
			end
			if (start_c || stop_c)
				sda_oe_r <= 1'b0;
			else if (last_fe && (st_r == PDI_RX || st_r == PDI_ADDR && match && enable))
				sda_oe_r <= 1'b1;
			else if (last_fe && st_r == PDI_TX)
				sda_oe_r <= 1'b0;
			else if (scl_fe && (st_r == PDI_AACK || st_r == PDI_RACK))
				sda_oe_r <= 1'b0;
			else if (st_r == PDI_TX && !hold_r && scl_fe)
				sda_oe_r <= ~sh_r[7 - cnt_r[2:0]];
			else if (hold_r && cif.tx_ready)
				sda_oe_r <= ~cif.tx_data[7];
			nack_r <= st_r == PDI_TACK && scl_re && sda;
		end
	end
	a_ack_held: assert property (@(posedge clk) disable iff (sys_rst)
		ce && st_r == PDI_AACK && scl |-> sda_oe) else $error("ack not held");
	a_nomatch_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		ce && last_fe && st_r == PDI_ADDR && !match |=> !sda_oe) else $error("nack bad");
	a_nack_release: assert property (@(posedge clk) disable iff (sys_rst)
		nack_r |-> !sda_oe && st_r == PDI_IDLE) else $error("no release");
	a_rx_ack: assert property (@(posedge clk) disable iff (sys_rst)
		ce && st_r == PDI_RX && last_fe |=> sda_oe) else $error("rx unacked");
	a_stable_high: assert property (@(posedge clk) disable iff (sys_rst)
		ce && scl && st_r == PDI_TX && !start_c |=> $stable(sda_oe) || !scl)
		else $error("sda moved");
	c_addr_ack: cover property (@(posedge clk) st_r == PDI_AACK);
	c_read_nack: cover property (@(posedge clk) nack_r);
	c_stretch: cover property (@(posedge clk) hold_r);
endmodule
`default_nettype wire

// file: rtl/pdi_ports.sv
// Top of the three two-wire ports: two targets toward the host, one controller outward.
// Assumes open-drain pads outside; every pin input is raw and asynchronous.
//
// Contract
// - Three ports; first selectable controller or target, target after reset.
// - Second port is target only and never starts transfers.
// - Third port is controller only, commanding external peripherals.
// - First and second targets behave identically with equal core access.
// - Each target has its own interrupt mask gating its interrupt line.
// - Standard-mode and fast-mode rates are supported.
// - Matching address is acknowledged with SDA low through the ack high phase.
// - One bit per pulse; SDA stable while SCL high.
// - Any number of bytes, eight bits each plus one ack.
// - Transmitter releases SDA before the ack bit.
// - Target receiver acknowledges every received byte.
// - Last read byte gets a high ack; target then releases SDA.
// - Target may hold SCL low after a byte until the core is ready.
// - Target address is fixed at boot before the port responds.
// - First port address is 0100, then three decode bits, then direction.
// - Second port address is 0111000 then direction bit.
// - Every address bit is maskable per port for firmware override.
// - Decode is 000b tied low, 001b/010b divider, 011b tied to rail.
`default_nettype none
module pdi_ports
	import pdi_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       ce,
	input  wire logic       boot_done,
	input  wire logic [2:0] address_select_decode,
	input  wire logic       port_a_ctrl_mode,
	input  wire logic       fast_mode,
	input  wire logic [6:0] port_a_addr_mask,
	input  wire logic [6:0] port_b_addr_mask,
	input  wire logic [6:0] fw_addr_a,
	input  wire logic [6:0] fw_addr_b,
	input  wire logic [7:0] events,
	input  wire logic [7:0] port_a_irq_mask,
	input  wire logic [7:0] port_b_irq_mask,
	input  wire logic [7:0] evt_clear_a,
	input  wire logic [7:0] evt_clear_b,
	input  wire logic [7:0] tx_data_a,
	input  wire logic [7:0] tx_data_b,
	input  wire logic       tx_valid_a,
	input  wire logic       tx_valid_b,
	output logic            tx_req_a,
	output logic            tx_req_b,
	output logic            rx_valid_a,
	output logic            rx_valid_b,
	output logic [7:0]      rx_data_a,
	output logic [7:0]      rx_data_b,
	output logic            port_a_busy,
	output logic            port_b_busy,
	output logic [7:0]      evt_pending_a,
	output logic [7:0]      evt_pending_b,
	input  wire logic       host_port_a_clock_line_in,
	output logic            host_port_a_clock_line_oe,
	input  wire logic       host_port_a_data_line_in,
	output logic            host_port_a_data_line_oe,
	output logic            host_port_a_irq,
	input  wire logic       host_port_b_clock_line_in,
	output logic            host_port_b_clock_line_oe,
	input  wire logic       host_port_b_data_line_in,
	output logic            host_port_b_data_line_oe,
	output logic            host_port_b_irq,
	input  wire logic       ctrl_cmd_valid,
	output logic            ctrl_cmd_ready,
	input  wire logic [6:0] ctrl_cmd_addr,
	input  wire logic [7:0] ctrl_cmd_data,
	output logic            ctrl_done,
	output logic            ctrl_nack,
	input  wire logic       ctrl_port_clock_line_in,
	output logic            ctrl_port_clock_line_oe,
	input  wire logic       ctrl_port_data_line_in,
	output logic            ctrl_port_data_line_oe,
	output logic            ctrl_port_irq
);
	pdi_core_if cif_a ();
	pdi_core_if cif_b ();
	logic [2:0]  decode_r;
	logic        addr_fixed_r;
	logic [6:0]  addr_a_r, addr_b_r;
	logic [7:0]  pend_a_r, pend_b_r;
	// The decode is captured once after reset release, never under the reset itself.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			decode_r     <= DECODE_RST;
			addr_fixed_r <= 1'b0;
			addr_a_r     <= 7'h00;
			addr_b_r     <= 7'h00;
		end else if (ce && boot_done && !addr_fixed_r) begin
			addr_fixed_r <= 1'b1;
			decode_r     <= address_select_decode;
			addr_a_r     <= {PORTA_ADDR_HI, address_select_decode};
			addr_b_r     <= PORTB_ADDR;
		end
	end
	// Mask bit high keeps the hardware bit; low hands the bit to firmware.
	wire [6:0] eff_a = (addr_a_r & port_a_addr_mask) | (fw_addr_a & ~port_a_addr_mask);
	wire [6:0] eff_b = (addr_b_r & port_b_addr_mask) | (fw_addr_b & ~port_b_addr_mask);
	wire       en_a  = addr_fixed_r & ~port_a_ctrl_mode;
	logic a_scl_oe, a_sda_oe, c_scl_oe, c_sda_oe;
	// Both targets are the same module, so their behaviour and core access cannot drift.
	pdi_target u_tgt_a (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.enable   (en_a),
		.own_addr (eff_a),
		.addr_mask(7'h7F),
		.scl_in   (host_port_a_clock_line_in),
		.sda_in   (host_port_a_data_line_in),
		.scl_oe   (a_scl_oe),
		.sda_oe   (a_sda_oe),
		.cif      (cif_a)
	);
	pdi_target u_tgt_b (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.enable   (addr_fixed_r),
		.own_addr (eff_b),
		.addr_mask(7'h7F),
		.scl_in   (host_port_b_clock_line_in),
		.sda_in   (host_port_b_data_line_in),
		.scl_oe   (host_port_b_clock_line_oe),
		.sda_oe   (host_port_b_data_line_oe),
		.cif      (cif_b)
	);
	// The first port's controller role reuses the third port's engine, one bus at a time.
	wire use_c_on_a = port_a_ctrl_mode;
	wire c_scl_in   = use_c_on_a ? host_port_a_clock_line_in : ctrl_port_clock_line_in;
	wire c_sda_in   = use_c_on_a ? host_port_a_data_line_in : ctrl_port_data_line_in;
	pdi_ctrl u_ctrl (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.fast_mode(fast_mode),
		.cmd_valid(ctrl_cmd_valid),
		.cmd_ready(ctrl_cmd_ready),
		.cmd_addr (ctrl_cmd_addr),
		.cmd_data (ctrl_cmd_data),
		.done     (ctrl_done),
		.nack     (ctrl_nack),
		.scl_in   (c_scl_in),
		.sda_in   (c_sda_in),
		.scl_oe   (c_scl_oe),
		.sda_oe   (c_sda_oe)
	);
	assign host_port_a_clock_line_oe = use_c_on_a ? c_scl_oe : a_scl_oe;
	assign host_port_a_data_line_oe  = use_c_on_a ? c_sda_oe : a_sda_oe;
	assign ctrl_port_clock_line_oe   = ~use_c_on_a & c_scl_oe;
	assign ctrl_port_data_line_oe    = ~use_c_on_a & c_sda_oe;
	assign ctrl_port_irq             = 1'b0;
	assign cif_a.tx_ready = tx_valid_a;
	assign cif_a.tx_data  = tx_data_a;
	assign cif_b.tx_ready = tx_valid_b;
	assign cif_b.tx_data  = tx_data_b;
	assign tx_req_a       = cif_a.tx_req;
	assign tx_req_b       = cif_b.tx_req;
	assign rx_valid_a     = cif_a.rx_valid;
	assign rx_valid_b     = cif_b.rx_valid;
	assign rx_data_a      = cif_a.rx_data;
	assign rx_data_b      = cif_b.rx_data;
	assign port_a_busy    = cif_a.busy;
	assign port_b_busy    = cif_b.busy;
	// A new event wins over a clear in the same cycle, so none is dropped.
	wire [7:0] pend_a_nxt = (pend_a_r & ~evt_clear_a) | events;
	wire [7:0] pend_b_nxt = (pend_b_r & ~evt_clear_b) | events;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_a_r <= EVT_RST;
			pend_b_r <= EVT_RST;
		end else if (ce) begin
			pend_a_r <= pend_a_nxt;
			pend_b_r <= pend_b_nxt;
		end
	end
	assign evt_pending_a   = pend_a_r;
	assign evt_pending_b   = pend_b_r;
	assign host_port_a_irq = |(pend_a_r & port_a_irq_mask);
	assign host_port_b_irq = |(pend_b_r & port_b_irq_mask);
	a_irq_masked: assert property (@(posedge clk) disable iff (sys_rst)
		(pend_a_r & port_a_irq_mask) == 8'h00 |-> !host_port_a_irq)
		else $error("irq a leak");
	a_irq_b_raise: assert property (@(posedge clk) disable iff (sys_rst)
		ce && |(events & port_b_irq_mask) |=> host_port_b_irq)
		else $error("irq b missed");
	a_addr_boot: assert property (@(posedge clk) disable iff (sys_rst)
		!addr_fixed_r |-> !host_port_b_data_line_oe && !a_sda_oe)
		else $error("answered before boot");
	a_addr_pattern: assert property (@(posedge clk) disable iff (sys_rst)
		addr_fixed_r |-> addr_a_r[6:3] == PORTA_ADDR_HI && addr_b_r == PORTB_ADDR)
		else $error("address wrong");
	a_b_no_ctrl: assert property (@(posedge clk) disable iff (sys_rst)
		!cif_b.busy |-> !host_port_b_data_line_oe)
		else $error("port b initiated");
	c_irq_a: cover property (@(posedge clk) host_port_a_irq);
	c_ctrl_mode: cover property (@(posedge clk) port_a_ctrl_mode && ctrl_done);
endmodule
`default_nettype wire

// file: rtl/pdi_ctrl.sv
// Controller engine: one-byte address write with start, ack check and stop.
// Assumes open-drain lines; SCL is sampled back so a stretching target is honoured.
`default_nettype none
module pdi_ctrl
	import pdi_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       ce,
	input  wire logic       fast_mode,
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic [6:0] cmd_addr,
	input  wire logic [7:0] cmd_data,
	output logic            done,
	output logic            nack,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_oe,
	output logic            sda_oe
);
	logic [1:0]   scl_s_r, sda_s_r;
	logic         sda_d_r, busy_bus_r;
	pdi_ctl_st_t  st_r;
	logic [DIV_W-1:0] tq_r;
	logic [1:0]   ph_r;
	logic [15:0]  sh_r;
	logic [4:0]   bit_r;
	logic         done_r, nack_r;
	wire scl   = scl_s_r[1];
	wire sda   = sda_s_r[1];
	wire [DIV_W-1:0] div = fast_mode ? DIV_W'(FM_DIV) : DIV_W'(SM_DIV);
	// Quarter ticks pause while SCL is released but still low: the target is stretching.
	wire stretched = ph_r == 2'h2 && !scl_oe && !scl;
	wire tick      = tq_r == div && !stretched;
	assign cmd_ready = st_r == PDC_IDLE && !busy_bus_r;
	assign done      = done_r;
	assign nack      = nack_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_s_r    <= 2'h3;
			sda_s_r    <= 2'h3;
			sda_d_r    <= 1'b1;
			busy_bus_r <= 1'b0;
		end else if (ce) begin
			scl_s_r <= {scl_s_r[0], scl_in};
			sda_s_r <= {sda_s_r[0], sda_in};
			sda_d_r <= sda;
			if (scl && sda_d_r && !sda && st_r == PDC_IDLE)
				busy_bus_r <= 1'b1;
			else if (scl && !sda_d_r && sda)
				busy_bus_r <= 1'b0;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r   <= PDC_IDLE;
			tq_r   <= '0;
			ph_r   <= 2'h0;
			sh_r   <= 16'h0000;
			bit_r  <= 5'h00;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			done_r <= 1'b0;
			nack_r <= 1'b0;
		end else if (ce) begin
			done_r <= 1'b0;
			tq_r   <= (tick || st_r == PDC_IDLE) ? '0 : (stretched ? tq_r : tq_r + 1'b1);
			if (tick)
				ph_r <= ph_r + 2'h1;
			unique case (st_r)
				PDC_IDLE: if (cmd_valid && cmd_ready) begin
					st_r   <= PDC_START;
					sh_r   <= {cmd_addr, 1'b0, cmd_data};
					bit_r  <= 5'h00;
					ph_r   <= 2'h0;
					nack_r <= 1'b0;
				end
				PDC_START: if (tick && ph_r == 2'h1) begin
					sda_oe <= 1'b1;
				end else if (tick && ph_r == 2'h3) begin
					scl_oe <= 1'b1;
					st_r   <= PDC_BIT;
				end
				PDC_BIT: if (tick) begin
					if (ph_r == 2'h0)
						sda_oe <= ~sh_r[15];
					else if (ph_r == 2'h1)
						scl_oe <= 1'b0;
					else if (ph_r == 2'h3) begin
						scl_oe <= 1'b1;
						sh_r   <= {sh_r[14:0], 1'b0};
						bit_r  <= bit_r + 5'h01;
						if (bit_r[2:0] == 3'h7)
							st_r <= PDC_ACK;
					end
				end
				PDC_ACK: if (tick) begin
					if (ph_r == 2'h0)
						sda_oe <= 1'b0;
					else if (ph_r == 2'h1)
						scl_oe <= 1'b0;
					else if (ph_r == 2'h2 && sda)
						nack_r <= 1'b1;
					else if (ph_r == 2'h3) begin
						scl_oe <= 1'b1;
						st_r   <= (nack_r || bit_r == 5'h10) ? PDC_STOP : PDC_BIT;
					end
				end
				PDC_STOP: if (tick) begin
					if (ph_r == 2'h0)
						sda_oe <= 1'b1;
					else if (ph_r == 2'h1)
						scl_oe <= 1'b0;
					else if (ph_r == 2'h2)
						sda_oe <= 1'b0;
					else begin
						st_r   <= PDC_IDLE;
						done_r <= 1'b1;
					end
				end
			endcase
		end
	end
	a_stop_order: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(sda_oe) && st_r == PDC_STOP |-> !scl_oe) else $error("bad stop");
	a_start_idle: assert property (@(posedge clk) disable iff (sys_rst)
		st_r == PDC_IDLE && cmd_valid && busy_bus_r |=> st_r == PDC_IDLE)
		else $error("start on busy");
	c_ctl_done: cover property (@(posedge clk) done_r && !nack_r);
endmodule
`default_nettype wire

// file: test/pdi_host_model.sv
// Two-wire host model for one target port at a time; drv=1 pulls the line low.
// Assumes the bench resolves each line with a pull-up; bit timing follows clk.
`default_nettype none
module pdi_host_model (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_drv,
	output logic      sda_drv
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl_drv = 1'b0;
		sda_drv = 1'b0;
	end
	task automatic q();
		repeat (2) @(posedge clk);
	endtask
	// Data moves only while SCL is low; a stretched low is waited out under a bound.
	task automatic bit_x(input logic b, output logic s);
		int n;
		sda_drv <= ~b;
		q();
		scl_drv <= 1'b0;
		n = 0;
		do @(posedge clk); while (!scl && n++ < 5000);
		q();
		s = sda;
		q();
		scl_drv <= 1'b1;
		q();
	endtask
	task automatic start();
		q();
		sda_drv <= 1'b1;
		q();
		scl_drv <= 1'b1;
		q();
	endtask
	task automatic stop();
		sda_drv <= 1'b1;
		q();
		scl_drv <= 1'b0;
		q();
		q();
		sda_drv <= 1'b0;
		q();
	endtask
	task automatic wr(input logic [7:0] d, output logic nak);
		for (int i = 7; i >= 0; i--) bit_x(d[i], nak);
		bit_x(1'b1, nak);
	endtask
	task automatic rd(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(last, s);
	endtask
endmodule
`default_nettype wire

// file: test/tb_pdi_ports.sv
// Self-checking bench: host model on the target ports, nobody answers the controller port.
// Assumes pull-ups on every line and a 50 MHz core clock.
`default_nettype none
module tb_pdi_ports;
	import pdi_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, sys_rst, ce, boot_done, port_a_ctrl_mode, fast_mode, tx_valid_a, tx_valid_b;
	logic tx_req_a, tx_req_b, rx_valid_a, rx_valid_b, port_a_busy, port_b_busy;
	logic host_port_a_irq, host_port_b_irq, sel_b, h_scl, h_sda, bus_scl, bus_sda;
	logic host_port_a_clock_line_in, host_port_a_clock_line_oe, host_port_a_data_line_in;
	logic host_port_a_data_line_oe, host_port_b_clock_line_in, host_port_b_clock_line_oe;
	logic host_port_b_data_line_in, host_port_b_data_line_oe, ctrl_cmd_valid, ctrl_cmd_ready;
	logic ctrl_done, ctrl_nack, ctrl_port_clock_line_oe, ctrl_port_data_line_oe, ctrl_port_irq;
	logic ctrl_port_clock_line_in, ctrl_port_data_line_in;
	logic [2:0] address_select_decode;
	logic [6:0] port_a_addr_mask, port_b_addr_mask, fw_addr_a, fw_addr_b, ctrl_cmd_addr;
	logic [7:0] events, port_a_irq_mask, port_b_irq_mask, evt_clear_a, evt_clear_b, ctrl_cmd_data;
	logic [7:0] tx_data_a, tx_data_b, rx_data_a, rx_data_b, evt_pending_a, evt_pending_b;
	logic [7:0] rxq[$], expq[$];
	int err_count, comparisons, cyc, rd_n;
	assign host_port_a_clock_line_in = ~(host_port_a_clock_line_oe | (h_scl & ~sel_b));
	assign host_port_a_data_line_in = ~(host_port_a_data_line_oe | (h_sda & ~sel_b));
	assign host_port_b_clock_line_in = ~(host_port_b_clock_line_oe | (h_scl & sel_b));
	assign host_port_b_data_line_in = ~(host_port_b_data_line_oe | (h_sda & sel_b));
	assign ctrl_port_clock_line_in = ~ctrl_port_clock_line_oe;
	assign ctrl_port_data_line_in = ~ctrl_port_data_line_oe;
	assign bus_scl = sel_b ? host_port_b_clock_line_in : host_port_a_clock_line_in;
	assign bus_sda = sel_b ? host_port_b_data_line_in : host_port_a_data_line_in;
	pdi_ports pdi_ports_i (.clk, .sys_rst, .ce, .boot_done, .address_select_decode,
		.port_a_ctrl_mode, .fast_mode, .port_a_addr_mask, .port_b_addr_mask, .fw_addr_a,
		.fw_addr_b, .events, .port_a_irq_mask, .port_b_irq_mask, .evt_clear_a, .evt_clear_b,
		.tx_data_a, .tx_data_b, .tx_valid_a, .tx_valid_b, .tx_req_a, .tx_req_b, .rx_valid_a,
		.rx_valid_b, .rx_data_a, .rx_data_b, .port_a_busy, .port_b_busy, .evt_pending_a,
		.evt_pending_b, .host_port_a_clock_line_in, .host_port_a_clock_line_oe,
		.host_port_a_data_line_in, .host_port_a_data_line_oe, .host_port_a_irq,
		.host_port_b_clock_line_in, .host_port_b_clock_line_oe, .host_port_b_data_line_in,
		.host_port_b_data_line_oe, .host_port_b_irq, .ctrl_cmd_valid, .ctrl_cmd_ready,
		.ctrl_cmd_addr, .ctrl_cmd_data, .ctrl_done, .ctrl_nack, .ctrl_port_clock_line_in,
		.ctrl_port_clock_line_oe, .ctrl_port_data_line_in, .ctrl_port_data_line_oe,
		.ctrl_port_irq);
	pdi_host_model pdi_host_model_i (.clk, .scl(bus_scl), .sda(bus_sda), .scl_drv(h_scl),
		.sda_drv(h_sda));
	always #10 clk = ~clk;
	function automatic logic [7:0] rd_val(input int n);
		return 8'(n * 29 + 60);
	endfunction
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Read data is offered late at random, so the port has to stretch SCL.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			results();
		end
		if ((tx_req_a & tx_valid_a) | (tx_req_b & tx_valid_b)) rd_n <= rd_n + 1;
		tx_valid_a <= tx_req_a & ($urandom_range(3) == 0);
		tx_valid_b <= tx_req_b & ($urandom_range(3) == 0);
		tx_data_a <= rd_val(rd_n);
		tx_data_b <= rd_val(rd_n);
		if (sel_b ? rx_valid_b : rx_valid_a) rxq.push_back(sel_b ? rx_data_b : rx_data_a);
	end
	task automatic boot(input logic [2:0] dv);
		sys_rst <= 1'b1;
		boot_done <= 1'b0;
		address_select_decode <= dv;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		boot_done <= 1'b1;
		@(posedge clk);
		address_select_decode <= dv ^ 3'h1;
		repeat (4) @(posedge clk);
	endtask
	task automatic frame(input logic [6:0] a, input logic rw, input int n, input logic ack);
		logic s;
		logic [7:0] d;
		int r0;
		r0 = rd_n;
		rxq.delete();
		expq.delete();
		pdi_host_model_i.start();
		pdi_host_model_i.wr({a, rw}, s);
		chk("address ack", {7'h0, ~ack}, {7'h0, s});
		for (int i = 0; i < n && ack; i++) begin
			if (rw) begin
				pdi_host_model_i.rd(i == n - 1, d);
				chk("read byte", rd_val(r0 + i), d);
			end else begin
				d = $urandom;
				expq.push_back(d);
				pdi_host_model_i.wr(d, s);
				chk("data ack", 8'h00, {7'h0, s});
			end
		end
		pdi_host_model_i.stop();
		repeat (4) @(posedge clk);
		chk("busy", 8'h00, {7'h0, sel_b ? port_b_busy : port_a_busy});
		foreach (expq[i]) chk("rx byte", expq[i], rxq[i]);
		chk("rx count", 8'(expq.size()), 8'(rxq.size()));
	endtask
	initial begin
		logic [6:0] m, f, a;
		logic [7:0] ev, ma, mb;
		int n;
		{clk, sys_rst, ce, boot_done, port_a_ctrl_mode, fast_mode, sel_b} = 7'h1A;
		{address_select_decode, port_a_addr_mask, port_b_addr_mask, fw_addr_a, fw_addr_b} = '0;
		{events, port_a_irq_mask, port_b_irq_mask, evt_clear_a, evt_clear_b} = '0;
		{ctrl_cmd_valid, ctrl_cmd_addr, ctrl_cmd_data, tx_valid_a, tx_valid_b} = '0;
		{tx_data_a, tx_data_b, cyc, rd_n, err_count, comparisons} = '0;
		void'($urandom(32'hB25D));
		for (int p = 0; p < 2; p++) begin
			for (int dv = 0; dv < 4; dv++) begin
				m = (dv == 3) ? 7'($urandom) : 7'h7F;
				f = 7'($urandom);
				@(posedge clk);
				sel_b <= p[0];
				{port_a_addr_mask, port_b_addr_mask, fw_addr_a, fw_addr_b} <= {m, m, f, f};
				boot(3'(dv));
				a = (m & (p[0] ? PORTB_ADDR : {PORTA_ADDR_HI, 3'(dv)})) | (f & ~m);
				frame(a, 1'b0, dv + 1, 1'b1);
				frame(a ^ 7'h01, 1'b0, 1, 1'b0);
				frame(a, 1'b1, dv + 1, 1'b1);
				$display("test port %0d decode %0d done", p, dv);
			end
		end
		for (int i = 0; i < 8; i++) begin
			ev = $urandom;
			ma = i ? 8'($urandom) : 8'h00;
			mb = i ? 8'($urandom) : 8'hFF;
			{events, port_a_irq_mask, port_b_irq_mask} <= {ev, ma, mb};
			@(posedge clk);
			events <= 8'h00;
			repeat (3) @(posedge clk);
			chk("pending a", ev, evt_pending_a);
			chk("irq a", {7'h0, |(ev & ma)}, {7'h0, host_port_a_irq});
			chk("irq b", {7'h0, |(ev & mb)}, {7'h0, host_port_b_irq});
			{evt_clear_a, evt_clear_b} <= 16'hFFFF;
			@(posedge clk);
			{evt_clear_a, evt_clear_b} <= 16'h0000;
			repeat (2) @(posedge clk);
			chk("cleared", 8'h00, evt_pending_a | evt_pending_b);
		end
		$display("test interrupt masks done");
		for (int i = 0; i < 2; i++) begin
			{fast_mode, ctrl_cmd_valid} <= {i[0], 1'b1};
			{ctrl_cmd_addr, ctrl_cmd_data} <= 15'($urandom);
			n = 0;
			while (ctrl_cmd_ready !== 1'b1 && n++ < 100) @(posedge clk);
			@(posedge clk);
			ctrl_cmd_valid <= 1'b0;
			n = 0;
			while (ctrl_done !== 1'b1 && n++ < 20000) @(posedge clk);
			chk("ctrl no ack", 8'h01, {7'h0, ctrl_nack});
			chk("ctrl rate", 8'h01, {7'h0, n > 40 * ((i ? FM_DIV : SM_DIV) + 1)
				&& n < 48 * ((i ? FM_DIV : SM_DIV) + 1)});
			$display("test controller rate %0d done", i);
		end
		results();
	end
endmodule
`default_nettype wire
